// ### tms_pkg.sv
// package: register map, field layout and timing constants of the timer mode block
package tms_pkg;
   // register indices (printed offsets not all multiples of four: byte address = index * 4)
   localparam logic [7:0]  IDX_TIMER_B_MODE   = 8'h09;
   localparam logic [7:0]  IDX_TIMER_C_MODE   = 8'h0d;
   localparam logic [7:0]  IDX_TIMER_A_MODE   = 8'h08;
   localparam logic [7:0]  IDX_LOAD_B         = 8'h10;
   localparam logic [7:0]  IDX_LOAD_C         = 8'h11;
   localparam logic [7:0]  IDX_STATUS         = 8'h12;
   localparam logic [7:0]  IDX_CONTROL        = 8'h13;
   localparam logic [7:0]  IDX_COUNT          = 8'h14;
   localparam logic [3:0]  MODE_RESET         = 4'h0;
   localparam logic [7:0]  LOAD_RESET         = 8'h00;
   localparam logic [7:0]  CNT_MAX            = 8'hff;
   localparam int          MODE_DELAY_CYC     = 2;
   // field positions
   localparam int          MODE_SEL_BIT       = 3;
   localparam int          STAT_IRQ_A         = 0;
   localparam int          STAT_IRQ_B         = 1;
   localparam int          STAT_IRQ_C         = 2;
   localparam int          STAT_DISP_ON       = 3;
   localparam int          CTRL_DISP_EN       = 0;
   localparam int          CTRL_PWM_EN        = 1;
   // subclock oscillator pre-divide ahead of the subclock prescaler
   localparam int          SUB_PREDIV_BITS    = 3;
   localparam int          SYS_PS_BITS        = 11;
   localparam int          SUB_PS_BITS        = 5;

   typedef struct packed {
      logic       reload_en;
      logic [2:0] rate;
   } tms_mode_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       irq;
   } tms_timer_t;
endpackage

// ### tms_timer_mode.sv
// top module: mode registers, prescalers and three 8-bit up-counters
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - timer_a_mode bit3=0: system prescaler taps 2048..2 cycles
// - bit3=1: subclock taps 32,16,8,2,1/2; 110/111 hold reset
// - timer A overflow every 256 input clocks
// - subclock or reset setting switches display power off
// - timer_b_mode 4-bit write-only, reset zero, bit3 auto-reload
// - timer B taps 2048..2, code 111 external event pin
// - timer B/C mode writes take effect second cycle after
// - timer_c_mode 4-bit write-only, reset zero, bit3 auto-reload
// - timer C taps 2048,1024,512,128,32,8,4,2, no external
// - pulse output may deviate until overflow after load update
// - after that overflow pulse output follows new settings
// - timer A increments per input clock, wraps at FF, flags
// - B/C reload value or zero on overflow, flag set
// - system prescaler 11-bit, cleared by reset
// - subclock prescaler 5-bit, fed by subclock divided by eight
module tms_timer_mode
   import tms_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // pins
   input  wire logic        subclk_in,
   input  wire logic        external_event_pin,
   // outputs
   output logic             timer_a_irq_flag,
   output logic             timer_b_irq_flag,
   output logic             timer_c_irq_flag,
   output logic             display_power,
   output logic             pwm_out
);
   tms_mode_t        mode_b_q, mode_c_q, pend_b_q, pend_c_q;
   logic [3:0]       mode_a_q;
   logic [1:0]       dly_b_q, dly_c_q;
   logic [7:0]       load_b_q, load_c_q;
   logic [1:0]       ctrl_q;
   logic [SYS_PS_BITS-1:0] sys_ps_q;
   logic [2:0]       sub_sync_q, ev_sync_q;
   logic [SUB_PREDIV_BITS-1:0] sub_div_q;
   logic [SUB_PS_BITS-1:0] sub_ps_q;
   logic [SUB_PS_BITS:0] sub_prev_q;
   logic [SYS_PS_BITS-1:0] sys_prev_q;
   tms_timer_t       ta_q, tb_q, tc_q;
   logic             pwm_stable_q;
   logic             wr, sub_edge, ev_edge, a_hold;
   logic             sub_half_prev_q;
   logic             tick_a, tick_b, tick_c;
   logic [SUB_PS_BITS:0] sub_chain;

   // tap index (0 = bit0 = /2) of system prescaler falling edge
   function automatic logic [3:0] tap_a(input logic [2:0] c);
      case (c)
         3'd0: tap_a = 4'd10;
         3'd1: tap_a = 4'd9;
         3'd2: tap_a = 4'd8;
         3'd3: tap_a = 4'd6;
         3'd4: tap_a = 4'd4;
         3'd5: tap_a = 4'd2;
         3'd6: tap_a = 4'd1;
         default: tap_a = 4'd0;
      endcase
   endfunction

   function automatic logic [3:0] tap_b(input logic [2:0] c);
      case (c)
         3'd0: tap_b = 4'd10;
         3'd1: tap_b = 4'd8;
         3'd2: tap_b = 4'd6;
         3'd3: tap_b = 4'd4;
         3'd4: tap_b = 4'd2;
         3'd5: tap_b = 4'd1;
         default: tap_b = 4'd0;
      endcase
   endfunction

   // edge of a system prescaler bit: falling edge marks one full tap period
   function automatic logic sys_fall(input logic [3:0] t,
                                     input logic [SYS_PS_BITS-1:0] p,
                                     input logic [SYS_PS_BITS-1:0] c);
      sys_fall = p[t] & ~c[t];
   endfunction

   assign wr = psel & penable & pwrite;

   // apb register writes; mode b/c staged for delayed effect
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_a_q <= MODE_RESET;
         pend_b_q <= tms_mode_t'(MODE_RESET);
         pend_c_q <= tms_mode_t'(MODE_RESET);
         load_b_q <= LOAD_RESET;
         load_c_q <= LOAD_RESET;
         ctrl_q   <= 2'b00;
      end else if (wr) begin
         if (paddr == {2'b00, IDX_TIMER_A_MODE, 2'b00}) begin
            mode_a_q <= pwdata[3:0];
         end else if (paddr == {2'b00, IDX_TIMER_B_MODE, 2'b00}) begin
            pend_b_q <= tms_mode_t'(pwdata[3:0]);
         end else if (paddr == {2'b00, IDX_TIMER_C_MODE, 2'b00}) begin
            pend_c_q <= tms_mode_t'(pwdata[3:0]);
         end else if (paddr == {2'b00, IDX_LOAD_B, 2'b00}) begin
            load_b_q <= pwdata[7:0];
         end else if (paddr == {2'b00, IDX_LOAD_C, 2'b00}) begin
            load_c_q <= pwdata[7:0];
         end else if (paddr == {2'b00, IDX_CONTROL, 2'b00}) begin
            ctrl_q <= pwdata[1:0];
         end
      end
   end

   // write to b/c mode becomes active on the second cycle after the write
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         dly_b_q  <= 2'd0;
         dly_c_q  <= 2'd0;
         mode_b_q <= tms_mode_t'(MODE_RESET);
         mode_c_q <= tms_mode_t'(MODE_RESET);
      end else begin
         dly_b_q <= (wr && paddr == {2'b00, IDX_TIMER_B_MODE, 2'b00}) ?
                    2'(MODE_DELAY_CYC) : (dly_b_q != 2'd0 ? dly_b_q - 2'd1 : 2'd0);
         dly_c_q <= (wr && paddr == {2'b00, IDX_TIMER_C_MODE, 2'b00}) ?
                    2'(MODE_DELAY_CYC) : (dly_c_q != 2'd0 ? dly_c_q - 2'd1 : 2'd0);
         if (dly_b_q == 2'd1) begin
            mode_b_q <= pend_b_q;
         end
         if (dly_c_q == 2'd1) begin
            mode_c_q <= pend_c_q;
         end
      end
   end

   // apb read data and answer: zero wait states, unmapped reads zero
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (paddr == {2'b00, IDX_STATUS, 2'b00}) begin
               prdata <= {28'h000_0000, display_power, timer_c_irq_flag,
                          timer_b_irq_flag, timer_a_irq_flag};
            end else if (paddr == {2'b00, IDX_COUNT, 2'b00}) begin
               prdata <= {8'h00, tc_q.cnt, tb_q.cnt, ta_q.cnt};
            end else if (paddr == {2'b00, IDX_CONTROL, 2'b00}) begin
               prdata <= {30'h0000_0000, ctrl_q};
            end
         end
      end
   end

   // system prescaler free-runs on the system clock
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sys_ps_q   <= '0;
         sys_prev_q <= '0;
      end else begin
         sys_ps_q   <= sys_ps_q + SYS_PS_BITS'(1);
         sys_prev_q <= sys_ps_q;
      end
   end

   // pin synchronisers; stage 0 only feeds stage 1
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sub_sync_q <= 3'b000;
         ev_sync_q  <= 3'b000;
      end else begin
         sub_sync_q <= {sub_sync_q[1:0], subclk_in};
         ev_sync_q  <= {ev_sync_q[1:0], external_event_pin};
      end
   end
   assign sub_edge = sub_sync_q[1] & ~sub_sync_q[2];
   assign ev_edge  = ev_sync_q[2] & ~ev_sync_q[1]; // falling edge of active-low event
   assign a_hold   = mode_a_q[MODE_SEL_BIT] & mode_a_q[2] & mode_a_q[1];

   // subclock /8 then 5-bit prescaler, held in reset by subclock codes 110/111
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sub_div_q  <= '0;
         sub_ps_q   <= '0;
         sub_prev_q <= '0;
         sub_half_prev_q <= 1'b0;
      end else begin
         if (a_hold) begin
            sub_div_q <= '0;
            sub_ps_q  <= '0;
         end else if (sub_edge) begin
            sub_div_q <= sub_div_q + SUB_PREDIV_BITS'(1);
            if (&sub_div_q) begin
               sub_ps_q <= sub_ps_q + SUB_PS_BITS'(1);
            end
         end
         sub_prev_q <= sub_chain;
         sub_half_prev_q <= sub_div_q[1]; // half of one /8 period
      end
   end
   // bit0 = divide-by-8 output (eight subclocks), bit k = 8*2^k subclocks
   assign sub_chain = {sub_ps_q, sub_div_q[SUB_PREDIV_BITS-1]};

   // tick selection for the three timers
   always_comb begin
      tick_a = 1'b0;
      if (!mode_a_q[MODE_SEL_BIT]) begin
         tick_a = sys_fall(tap_a(mode_a_q[2:0]), sys_prev_q, sys_ps_q);
      end else begin
         case (mode_a_q[2:0])
            3'd0: tick_a = sub_prev_q[5] & ~sub_chain[5];
            3'd1: tick_a = sub_prev_q[4] & ~sub_chain[4];
            3'd2: tick_a = sub_prev_q[3] & ~sub_chain[3];
            3'd3: tick_a = sub_prev_q[1] & ~sub_chain[1];
            3'd4: tick_a = sub_half_prev_q & ~sub_div_q[1]; // tick every four subclocks, half a /8 period
            default: tick_a = 1'b0;
         endcase
      end
      tick_b = (mode_b_q.rate == 3'd7) ? ev_edge :
               sys_fall(tap_b(mode_b_q.rate), sys_prev_q, sys_ps_q);
      tick_c = sys_fall(tap_a(mode_c_q.rate), sys_prev_q, sys_ps_q);
   end

   // timer A counter: wraps after FF, flag sticky until cleared by status write
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ta_q <= '0;
      end else begin
         if (a_hold) begin
            ta_q.cnt <= 8'h00;
         end else if (tick_a) begin
            ta_q.cnt <= ta_q.cnt + 8'h01;
         end
         if (a_hold == 1'b0 && tick_a && ta_q.cnt == CNT_MAX) begin
            ta_q.irq <= 1'b1;
         end else if (wr && paddr == {2'b00, IDX_STATUS, 2'b00} && pwdata[STAT_IRQ_A]) begin
            ta_q.irq <= 1'b0;
         end
      end
   end

   // timers B and C: reload value or zero on overflow, load write restarts
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tb_q <= '0;
         tc_q <= '0;
      end else begin
         if (wr && paddr == {2'b00, IDX_LOAD_B, 2'b00}) begin
            tb_q.cnt <= pwdata[7:0];
         end else if (tick_b) begin
            tb_q.cnt <= (tb_q.cnt != CNT_MAX) ? tb_q.cnt + 8'h01 :
                        (mode_b_q.reload_en ? load_b_q : 8'h00);
         end
         if (tick_b && tb_q.cnt == CNT_MAX) begin
            tb_q.irq <= 1'b1;
         end else if (wr && paddr == {2'b00, IDX_STATUS, 2'b00} && pwdata[STAT_IRQ_B]) begin
            tb_q.irq <= 1'b0;
         end
         if (wr && paddr == {2'b00, IDX_LOAD_C, 2'b00}) begin
            tc_q.cnt <= pwdata[7:0];
         end else if (tick_c) begin
            tc_q.cnt <= (tc_q.cnt != CNT_MAX) ? tc_q.cnt + 8'h01 :
                        (mode_c_q.reload_en ? load_c_q : 8'h00);
         end
         if (tick_c && tc_q.cnt == CNT_MAX) begin
            tc_q.irq <= 1'b1;
         end else if (wr && paddr == {2'b00, IDX_STATUS, 2'b00} && pwdata[STAT_IRQ_C]) begin
            tc_q.irq <= 1'b0;
         end
      end
   end

   // pulse output from timer C: muted after a load write until its overflow
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pwm_stable_q <= 1'b0;
         pwm_out      <= 1'b0;
      end else begin
         if (wr && paddr == {2'b00, IDX_LOAD_C, 2'b00}) begin
            pwm_stable_q <= 1'b0;
         end else if (tick_c && tc_q.cnt == CNT_MAX) begin
            pwm_stable_q <= 1'b1;
         end
         pwm_out <= ctrl_q[CTRL_PWM_EN] & pwm_stable_q & (tc_q.cnt >= load_c_q) & ~tc_q.cnt[7]
                    | (ctrl_q[CTRL_PWM_EN] & pwm_stable_q & tc_q.cnt[7] & (tc_q.cnt >= load_c_q));
      end
   end

   // display power: off whenever subclock source or hold setting is selected
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         display_power <= 1'b0;
      end else begin
         display_power <= ctrl_q[CTRL_DISP_EN] & ~mode_a_q[MODE_SEL_BIT];
      end
   end

   // flag outputs
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         timer_a_irq_flag <= 1'b0;
         timer_b_irq_flag <= 1'b0;
         timer_c_irq_flag <= 1'b0;
      end else begin
         timer_a_irq_flag <= ta_q.irq;
         timer_b_irq_flag <= tb_q.irq;
         timer_c_irq_flag <= tc_q.irq;
      end
   end

   // checks; the staged mode is visible one edge after the second cycle
   mode_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr && paddr == {2'b00, IDX_TIMER_B_MODE, 2'b00}) ##1 !wr [*2]
      |=> mode_b_q == $past(pend_b_q))
      else $error("timer b mode not applied after two cycles");
   b_reload_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_b && tb_q.cnt == CNT_MAX && mode_b_q.reload_en && !wr) |=> tb_q.cnt == load_b_q)
      else $error("timer b reload value wrong");
   b_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_b && tb_q.cnt == CNT_MAX && !mode_b_q.reload_en && !wr) |=> tb_q.cnt == 8'h00)
      else $error("timer b did not restart at zero");
   a_wrap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_a && !a_hold && ta_q.cnt == CNT_MAX)
      |=> ta_q.cnt == 8'h00 && ta_q.irq ##1 timer_a_irq_flag)
      else $error("timer a overflow wrong");
   a_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      a_hold |=> ta_q.cnt == 8'h00 && sub_ps_q == '0)
      else $error("timer a not held in reset");
   disp_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      mode_a_q[MODE_SEL_BIT] |=> !display_power)
      else $error("display still powered");
   a_tap_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode_a_q == 4'h7 && $past(mode_a_q) == 4'h7 && tick_a) |=> !tick_a)
      else $error("fastest timer a tap ticked back to back");
   c_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (tick_c && tc_q.cnt != CNT_MAX && !wr) |=> tc_q.cnt == $past(tc_q.cnt) + 8'h01)
      else $error("timer c did not step by one");
   pwm_mute_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (wr && paddr == {2'b00, IDX_LOAD_C, 2'b00}) |=> !pwm_stable_q ##1 !pwm_out)
      else $error("pulse output not muted after load");
   ovf_b_c: cover property (@(posedge ref_clk) disable iff (!nrst) tick_b && tb_q.cnt == CNT_MAX);
   ovf_a_c: cover property (@(posedge ref_clk) disable iff (!nrst) tick_a && ta_q.cnt == CNT_MAX);
   ev_b_c:  cover property (@(posedge ref_clk) disable iff (!nrst) ev_edge && mode_b_q.rate == 3'd7);
endmodule
`default_nettype wire

// ### tms_timer_mode_tb.sv
// testbench: self-checking run of the timer mode block over apb
`timescale 1ns/1ps
`default_nettype none
module tms_timer_mode_tb;
   import tms_pkg::*;
   logic        ref_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        subclk_in;
   logic        ext_event_n;
   logic        irq_a;
   logic        irq_b;
   logic        irq_c;
   logic        disp_pwr;
   logic        pwm_out;
   logic [3:0]  sub_div;
   logic [31:0] rdv;
   logic        errv;
   int          fails;
   int          check_count;
   localparam int TAP_AC [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
   localparam int TAP_B  [7] = '{2048, 512, 128, 32, 8, 4, 2};
   localparam logic [7:0] RD_IDX [5] = '{IDX_TIMER_A_MODE, IDX_TIMER_B_MODE,
                                         IDX_TIMER_C_MODE, IDX_STATUS, 8'h3f};

   tms_timer_mode DUT (
      .ref_clk            (ref_clk),
      .nrst               (nrst),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .paddr              (paddr),
      .pwdata             (pwdata),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .subclk_in          (subclk_in),
      .external_event_pin (ext_event_n),
      .timer_a_irq_flag   (irq_a),
      .timer_b_irq_flag   (irq_b),
      .timer_c_irq_flag   (irq_c),
      .display_power      (disp_pwr),
      .pwm_out            (pwm_out)
   );

   // 20 MHz system clock
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // free-running subclock, one period every 4 system clocks
   always @(posedge ref_clk) begin
      sub_div <= (sub_div == 4'h1) ? 4'h0 : sub_div + 4'h1;
      if (sub_div == 4'h1) begin
         subclk_in <= ~subclk_in;
      end
   end

   // verdict and end of run
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic timed_out;
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      report_and_stop();
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) timed_out();
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic flag(input int w);
      return (w == 0) ? irq_a : (w == 1) ? irq_b : irq_c;
   endfunction

   // bounded wait for a flag; two edges pass first so that a flag cleared
   // by the status write just before no longer shows its stale value
   task automatic wait_flag(input int w, input int lim);
      int n;
      n = 0;
      @(posedge ref_clk);
      do begin
         @(posedge ref_clk);
         n++;
      end while (flag(w) !== 1'b1 && n < lim);
      if (flag(w) !== 1'b1) timed_out();
   endtask

   // distance in clocks between two successive overflows
   task automatic per_chk(input int w, input int cyc);
      time t1;
      apb(1'b1, IDX_STATUS, 32'h1 << w);
      wait_flag(w, cyc + 200);
      t1 = $time;
      apb(1'b1, IDX_STATUS, 32'h1 << w);
      wait_flag(w, cyc + 20);
      chk(32'(($time - t1) / 50), 32'(cyc));
   endtask

   // one falling edge on the event pin, long enough for the synchroniser
   task automatic ev_pulse;
      ext_event_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ext_event_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask

   // auto-reload on, load chosen so the overflow period is short but measurable
   task automatic tap_run(input int w, input logic [7:0] mi, input logic [7:0] li,
                          input int code, input int tap);
      apb(1'b1, mi, 32'(8 + code));
      repeat (3) @(posedge ref_clk);
      apb(1'b1, li, (tap >= 32) ? 32'h0000_00ff : 32'h0000_00f0);
      per_chk(w, (tap >= 32) ? tap : tap * 16);
   endtask

   // outputs idle, write-only and unmapped places read zero
   task automatic t_reset;
      @(posedge ref_clk);
      chk({pready, pslverr, irq_a, irq_b, irq_c, disp_pwr, pwm_out}, 32'h0);
      apb(1'b1, IDX_TIMER_C_MODE, 32'h0000_0007);
      apb(1'b1, 8'h3f, 32'h0000_ffff);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, RD_IDX[i], 32'h0);
         chk(rdv, 32'h0);
         chk(32'(errv), 32'h0);
      end
      apb(1'b1, IDX_TIMER_C_MODE, 32'h0000_0000);
   endtask

   // interval taps, display shut-off, time base and counter hold
   task automatic t_timer_a;
      for (int c = 7; c >= 5; c--) begin
         apb(1'b1, IDX_TIMER_A_MODE, 32'(c));
         per_chk(0, TAP_AC[c] * 256);
      end
      apb(1'b1, IDX_CONTROL, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      chk(32'(disp_pwr), 32'h1);
      apb(1'b1, IDX_TIMER_A_MODE, 32'h0000_000c);
      repeat (3) @(posedge ref_clk);
      chk(32'(disp_pwr), 32'h0);
      per_chk(0, 16 * 256);
      apb(1'b1, IDX_TIMER_A_MODE, 32'h0000_000e);
      repeat (100) @(posedge ref_clk);
      apb(1'b0, IDX_COUNT, 32'h0);
      chk({disp_pwr, rdv[7:0]}, 32'h0);
   endtask

   // external event clocking of timer B, with and without reload
   task automatic t_ext_b;
      for (int r = 0; r < 2; r++) begin
         apb(1'b1, IDX_TIMER_B_MODE, 32'({r[0], 3'b111}));
         repeat (3) @(posedge ref_clk);
         apb(1'b1, IDX_STATUS, 32'h0000_0002);
         apb(1'b1, IDX_LOAD_B, 32'h0000_00fd);
         repeat (2) ev_pulse();
         apb(1'b0, IDX_COUNT, 32'h0);
         chk({irq_b, rdv[15:8]}, 32'h0000_00ff);
         ev_pulse();
         apb(1'b0, IDX_COUNT, 32'h0);
         chk({irq_b, rdv[15:8]}, (r == 1) ? 32'h0000_01fd : 32'h0000_0100);
      end
   endtask

   // every prescaler code of timers B and C, pwm checked after the first timer C overflow
   task automatic t_taps;
      apb(1'b1, IDX_CONTROL, 32'h0000_0002);
      for (int c = 0; c < 8; c++) begin
         tap_run(2, IDX_TIMER_C_MODE, IDX_LOAD_C, c, TAP_AC[c]);
         if (c == 0) begin
            chk(32'(pwm_out), 32'h1);
         end
         if (c < 7) begin
            tap_run(1, IDX_TIMER_B_MODE, IDX_LOAD_B, c, TAP_B[c]);
         end
      end
   endtask

   // main sequence
   initial begin
      nrst        = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 12'h000;
      pwdata      = 32'h0;
      ext_event_n = 1'b1;
      subclk_in   = 1'b0;
      sub_div     = 4'h0;
      fails       = 0;
      check_count = 0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_timer_a();
      t_ext_b();
      t_taps();
      report_and_stop();
   end
endmodule
`default_nettype wire
